// *** src/fmf_follower_framer.sv ***
// follower framer: receive, check, answer serial requests in binary or text form
//
// Notes on behaviour
// - frames hold at most 80 bytes
// - text frames: colon start, CR LF end
// - one response per addressed request only
// - binary frame: address, function, data, CRC, gap
// - response leaves 10 ms after valid request
// - address zero is broadcast to all
// - accept own station 01..FE only
// - functions 03, 06, 08, 10 supported
// - CRC spans address through last data
// - CRC starts at all ones
// - per bit: shift right, xor A001 on carry
// - CRC sent low byte then high
// - errors: function with bit 7, one code
`timescale 1ns/100ps
module fmf_follower_framer
  import fmf_pkg::*;
#(
  parameter int RESP_CYCLES = RESP_DELAY_CYC,
  parameter int IW          = $clog2(MAX_FRAME)
) (
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic          asciiMode,
  input  wire logic [7:0]    stationId,
  input  wire logic          rxValid,
  input  wire logic [7:0]    rxByte,
  input  wire logic          rxIdle,
  output logic               txValid,
  output logic      [7:0]    txByte,
  input  wire logic          txReady,
  output logic               appReq,
  output fmf_hdr_t           appHdr,
  input  wire logic [IW-1:0] appRdIdx,
  output logic      [7:0]    appRdByte,
  input  wire logic          appWrEn,
  input  wire logic [IW-1:0] appWrIdx,
  input  wire logic [7:0]    appWrByte,
  input  wire logic          appDone,
  input  wire logic [2:0]    appExc
);
  // ==========================================
  // helpers
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    return (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction

  function automatic logic [4:0] hex_val(input logic [7:0] ch);
    if (ch >= 8'h30 && ch <= 8'h39) return {1'b1, ch[3:0]};
    if ((ch >= 8'h41 && ch <= 8'h46) || (ch >= 8'h61 && ch <= 8'h66)) return {1'b1, ch[3:0] + 4'h9};
    return 5'h00;
  endfunction

  // ==========================================
  // state
  fmf_state_t  state_reg, state_next;
  fmf_hdr_t    hdr_reg, hdr_next;
  logic [IW-1:0] len_reg, len_next, pos_reg, pos_next, respLen_reg, respLen_next;
  logic [15:0] crc_reg, crc_next;
  logic [7:0]  lrc_reg, lrc_next, txByte_reg, txByte_next;
  logic [3:0]  hi_reg, hi_next;
  logic [2:0]  exc_reg, exc_next;
  logic [1:0]  tail_reg, tail_next;
  logic [16:0] waitCnt_reg, waitCnt_next;
  logic        nib_reg, nib_next, cr_reg, cr_next, bad_reg, bad_next;
  logic        bcast_reg, bcast_next, txValid_reg, txValid_next;
  logic        wrEn, binValid, txLoad, slotFree, frameOk, addrOk;
  logic [IW-1:0] wrAddr, rdAddr, rxIdx;
  logic [7:0]  wrData, binByte, txChar, rdData, selByte;
  logic [4:0]  hv;
  logic [2:0]  excCalc;

  fmf_frame_mem #(.WIDTH(8), .DEPTH(MAX_FRAME), .AW(IW)) u_mem (
    .clk    (clk),
    .rst_b  (rst_b),
    .wrEn   (wrEn),
    .wrAddr (wrAddr),
    .wrData (wrData),
    .rdAddr (rdAddr),
    .rdData (rdData)
  );

  // read port belongs to the application while it serves a request
  assign rdAddr    = (state_reg == ST_APP) ? appRdIdx : pos_reg;
  assign appRdByte = rdData;
  assign appReq    = (state_reg == ST_APP);
  assign appHdr    = hdr_reg;
  assign txValid   = txValid_reg;
  assign txByte    = txByte_reg;
  assign slotFree  = !txValid_reg || txReady;

  // ==========================================
  // request checks
  always_comb begin
    frameOk = !bad_reg && (asciiMode ? (len_reg >= IW'(3) && lrc_reg == 8'h00 && !nib_reg)
                                     : (len_reg >= IW'(4) && crc_reg == 16'h0000));
    addrOk  = (hdr_reg.addr == BCAST_ADDR) ||
              (stationId >= STN_MIN && stationId <= STN_MAX && hdr_reg.addr == stationId);
    case (hdr_reg.func)
      FN_READ:   excCalc = (hdr_reg.count == 16'h0000 || hdr_reg.count > 16'(MAX_READ_WORDS)) ? EXC_COUNT : EXC_NONE;
      FN_WRITEN: excCalc = (hdr_reg.count == 16'h0000 || hdr_reg.count > 16'(MAX_READ_WORDS) ||
                            {8'h00, hdr_reg.byteCnt} != (hdr_reg.count << 1)) ? EXC_COUNT : EXC_NONE;
      FN_WRITE1, FN_LOOP: excCalc = EXC_NONE;
      default:   excCalc = EXC_FUNC;
    endcase
    // response byte with exception and byte-count overrides
    if (pos_reg == IW'(1) && exc_reg != EXC_NONE) begin
      selByte = hdr_reg.func | EXC_FLAG;
    end else if (pos_reg == IW'(2) && exc_reg != EXC_NONE) begin
      selByte = {5'h00, exc_reg};
    end else if (pos_reg == IW'(2) && hdr_reg.func == FN_READ) begin
      selByte = {hdr_reg.count[6:0], 1'b0};
    end else begin
      selByte = rdData;
    end
  end

  // ==========================================
  // next-state logic of the whole framer
  always_comb begin
    state_next = state_reg;   hdr_next = hdr_reg;         len_next = len_reg;
    pos_next = pos_reg;       respLen_next = respLen_reg; crc_next = crc_reg;
    lrc_next = lrc_reg;       hi_next = hi_reg;           exc_next = exc_reg;
    tail_next = tail_reg;     waitCnt_next = waitCnt_reg; nib_next = nib_reg;
    cr_next = cr_reg;         bad_next = bad_reg;         bcast_next = bcast_reg;
    wrEn = 1'b0;              wrAddr = len_reg;           wrData = 8'h00;
    binValid = 1'b0;          binByte = rxByte;           txLoad = 1'b0;
    txChar = 8'h00;           hv = hex_val(rxByte);
    rxIdx = (state_reg == ST_IDLE) ? '0 : len_reg; // a byte taken in idle always opens at index zero
    case (state_reg)
      ST_IDLE: begin
        bcast_next = 1'b0;
        exc_next   = EXC_NONE;
        len_next   = '0;
        bad_next   = 1'b0;
        nib_next   = 1'b0;
        cr_next    = 1'b0;
        if (rxValid && asciiMode && rxByte == ASC_START) begin
          state_next = ST_RECV;
        end else if (rxValid && !asciiMode) begin
          state_next = ST_RECV;
          binValid   = 1'b1;
        end
      end
      ST_RECV: begin
        if (!asciiMode) begin
          binValid = rxValid;
          if (rxIdle) state_next = ST_CHECK;
        end else if (rxValid) begin
          if (rxByte == ASC_START) begin // a new start abandons the partial frame
            len_next = '0; nib_next = 1'b0; cr_next = 1'b0; bad_next = 1'b0;
            crc_next = CRC_INIT; lrc_next = 8'h00;
          end else if (cr_reg) begin
            if (rxByte == ASC_LF) state_next = ST_CHECK;
            else bad_next = 1'b1;
          end else if (rxByte == ASC_CR) begin
            cr_next = 1'b1;
          end else if (!hv[4]) begin
            bad_next = 1'b1;
          end else if (!nib_reg) begin
            hi_next = hv[3:0]; nib_next = 1'b1;
          end else begin
            binValid = 1'b1; binByte = {hi_reg, hv[3:0]}; nib_next = 1'b0;
          end
        end
      end
      ST_CHECK: begin
        waitCnt_next = '0;
        crc_next     = CRC_INIT;
        lrc_next     = 8'h00; // dropped frames must not leave a stale sum behind
        bcast_next   = (hdr_reg.addr == BCAST_ADDR);
        exc_next     = excCalc;
        if (!frameOk || !addrOk) state_next = ST_IDLE;
        else if (excCalc != EXC_NONE || hdr_reg.func == FN_LOOP)
          state_next = (hdr_reg.addr == BCAST_ADDR) ? ST_IDLE : ST_WAIT;
        else state_next = ST_APP;
      end
      ST_APP: begin
        wrEn = appWrEn; wrAddr = appWrIdx; wrData = appWrByte;
        if (waitCnt_reg != 17'(RESP_CYCLES - 1)) begin
          waitCnt_next = waitCnt_reg + 17'h0_0001; // delay runs from frame end, service time included
        end
        if (appDone) begin
          exc_next   = appExc;
          state_next = bcast_reg ? ST_IDLE : ST_WAIT;
        end
      end
      ST_WAIT: begin
        respLen_next = (exc_reg != EXC_NONE) ? IW'(3) :
                       (hdr_reg.func == FN_READ) ? IW'(7'd3 + (hdr_reg.count[6:0] << 1)) :
                       (hdr_reg.func == FN_WRITEN) ? IW'(6) :
                       (asciiMode ? len_reg - IW'(1) : len_reg - IW'(2));
        if (waitCnt_reg != 17'(RESP_CYCLES - 1)) begin
          waitCnt_next = waitCnt_reg + 17'h0_0001;
        end else if (slotFree) begin
          state_next = ST_FETCH; pos_next = '0; nib_next = 1'b0; tail_next = 2'h0;
          crc_next = CRC_INIT; lrc_next = 8'h00;
          txLoad = asciiMode; txChar = ASC_START;
        end
      end
      ST_FETCH: state_next = ST_EMIT;
      ST_EMIT: if (slotFree) begin
        txLoad = 1'b1;
        if (pos_reg < respLen_reg) begin
          if (!asciiMode) begin
            txChar = selByte; crc_next = crc_step(crc_reg, selByte);
            pos_next = pos_reg + IW'(1); state_next = ST_FETCH;
          end else if (!nib_reg) begin
            txChar = hex_char(selByte[7:4]); nib_next = 1'b1;
          end else begin
            txChar = hex_char(selByte[3:0]); lrc_next = lrc_reg + selByte; nib_next = 1'b0;
            pos_next = pos_reg + IW'(1); state_next = ST_FETCH;
          end
        end else begin
          tail_next = tail_reg + 2'h1;
          case (tail_reg)
            2'h0: txChar = asciiMode ? hex_char(4'((8'h00 - lrc_reg) >> 4)) : crc_reg[7:0];
            2'h1: txChar = asciiMode ? hex_char(4'(8'h00 - lrc_reg)) : crc_reg[15:8];
            2'h2: txChar = ASC_CR;
            default: txChar = ASC_LF;
          endcase
          if (tail_reg == 2'h3 || (!asciiMode && tail_reg == 2'h1)) begin
            state_next = ST_IDLE; crc_next = CRC_INIT; lrc_next = 8'h00;
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
    // received binary byte: store, accumulate checks, catch header fields
    if (binValid) begin
      if (rxIdx < IW'(MAX_FRAME)) begin
        wrEn = 1'b1; wrAddr = rxIdx; wrData = binByte;
        crc_next = crc_step(crc_reg, binByte);
        lrc_next = lrc_reg + binByte;
        len_next = rxIdx + IW'(1);
        case (rxIdx)
          IW'(0): hdr_next.addr = binByte;
          IW'(1): hdr_next.func = binByte;
          IW'(2): hdr_next.regAddr[15:8] = binByte;
          IW'(3): hdr_next.regAddr[7:0] = binByte;
          IW'(4): hdr_next.count[15:8] = binByte;
          IW'(5): hdr_next.count[7:0] = binByte;
          IW'(6): hdr_next.byteCnt = binByte;
          default: hdr_next = hdr_reg;
        endcase
      end else begin
        bad_next = 1'b1;
      end
    end
    // transmit holding register
    txValid_next = txLoad || (txValid_reg && !txReady);
    txByte_next  = txLoad ? txChar : txByte_reg;
  end

  // registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;  hdr_reg <= '0;       len_reg <= '0;      pos_reg <= '0;
      respLen_reg <= '0;     crc_reg <= CRC_INIT; lrc_reg <= 8'h00;   hi_reg <= 4'h0;
      exc_reg <= EXC_NONE;   tail_reg <= 2'h0;    waitCnt_reg <= '0;  nib_reg <= 1'b0;
      cr_reg <= 1'b0;        bad_reg <= 1'b0;     bcast_reg <= 1'b0;  txValid_reg <= 1'b0;
      txByte_reg <= 8'h00;
    end else begin
      state_reg <= state_next;     hdr_reg <= hdr_next;   len_reg <= len_next;
      pos_reg <= pos_next;         respLen_reg <= respLen_next;
      crc_reg <= crc_next;         lrc_reg <= lrc_next;   hi_reg <= hi_next;
      exc_reg <= exc_next;         tail_reg <= tail_next; waitCnt_reg <= waitCnt_next;
      nib_reg <= nib_next;         cr_reg <= cr_next;     bad_reg <= bad_next;
      bcast_reg <= bcast_next;     txValid_reg <= txValid_next;
      txByte_reg <= txByte_next;
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_crSent;
    asciiMode && txValid_reg && txReady && txByte_reg == ASC_CR;
  endsequence
  sequence s_lfNext;
    txValid_reg && txByte_reg == ASC_LF;
  endsequence

  chk_len_bound: assert property (binValid && rxIdx == IW'(MAX_FRAME) |=> bad_reg)
    else $error("byte beyond maximum frame length not refused");
  chk_ascii_start: assert property (state_reg == ST_IDLE && asciiMode && rxValid && rxByte != ASC_START
    |=> state_reg == ST_IDLE)
    else $error("text frame began without start character");
  chk_ascii_tail: assert property (s_crSent |=> s_lfNext)
    else $error("line feed did not follow carriage return");
  chk_bcast_silent: assert property (bcast_reg |-> state_reg != ST_WAIT && state_reg != ST_EMIT)
    else $error("broadcast request is being answered");
  chk_resp_delay: assert property (state_reg == ST_WAIT && state_next != ST_WAIT
    |-> waitCnt_reg == 17'(RESP_CYCLES - 1))
    else $error("response delay cut short");
  chk_addr_filter: assert property (state_reg == ST_CHECK && hdr_reg.addr != BCAST_ADDR &&
    hdr_reg.addr != stationId |=> state_reg == ST_IDLE)
    else $error("frame for another station accepted");
  chk_exc_func: assert property (state_reg == ST_CHECK && frameOk && addrOk && excCalc == EXC_FUNC &&
    hdr_reg.addr != BCAST_ADDR |=> state_reg == ST_WAIT && exc_reg == EXC_FUNC)
    else $error("unsupported function not refused");
  chk_crc_init: assert property (state_reg == ST_IDLE |-> crc_reg == CRC_INIT)
    else $error("checksum accumulator not at initial value");
  chk_exc_bit7: assert property (state_reg == ST_EMIT && txLoad && !asciiMode && pos_reg == IW'(1) &&
    exc_reg != EXC_NONE |=> txByte_reg[7])
    else $error("exception reply lacks error flag");
endmodule

// *** src/fmf_pkg.sv ***
// shared constants, header carrier and states of the follower framer
package fmf_pkg;
  // ==========================================
  // frame limits and characters
  localparam int         MAX_FRAME       = 80;
  localparam int         MAX_READ_WORDS  = (MAX_FRAME - 5) / 2;
  localparam logic [15:0] CRC_INIT       = 16'hFFFF;
  localparam logic [15:0] CRC_POLY       = 16'hA001;
  localparam logic [7:0] ASC_START       = 8'h3A;
  localparam logic [7:0] ASC_CR          = 8'h0D;
  localparam logic [7:0] ASC_LF          = 8'h0A;
  localparam logic [7:0] BCAST_ADDR      = 8'h00;
  localparam logic [7:0] STN_MIN         = 8'h01;
  localparam logic [7:0] STN_MAX         = 8'hFE;
  localparam logic [7:0] EXC_FLAG        = 8'h80;
  // ==========================================
  // function and exception codes
  localparam logic [7:0] FN_READ         = 8'h03;
  localparam logic [7:0] FN_WRITE1       = 8'h06;
  localparam logic [7:0] FN_LOOP         = 8'h08;
  localparam logic [7:0] FN_WRITEN       = 8'h10;
  localparam logic [2:0] EXC_NONE        = 3'h0;
  localparam logic [2:0] EXC_FUNC        = 3'h1;
  localparam logic [2:0] EXC_REG         = 3'h2;
  localparam logic [2:0] EXC_COUNT       = 3'h3;
  localparam logic [2:0] EXC_DATA        = 3'h4;
  // ==========================================
  // timing
  localparam int         RESP_DELAY_NS   = 10_000_000;
  localparam int         CLK_PERIOD_NS   = 100;
  localparam int         RESP_DELAY_CYC  = RESP_DELAY_NS / CLK_PERIOD_NS;
  // ==========================================
  // types
  typedef struct packed {
    logic [7:0]  addr;
    logic [7:0]  func;
    logic [15:0] regAddr;
    logic [15:0] count;
    logic [7:0]  byteCnt;
  } fmf_hdr_t;
  typedef enum logic [6:0] {
    ST_IDLE  = 7'b000_0001,
    ST_RECV  = 7'b000_0010,
    ST_CHECK = 7'b000_0100,
    ST_APP   = 7'b000_1000,
    ST_WAIT  = 7'b001_0000,
    ST_FETCH = 7'b010_0000,
    ST_EMIT  = 7'b100_0000
  } fmf_state_t;
endpackage

// *** src/fmf_frame_mem.sv ***
// frame byte store with registered read data
`timescale 1ns/100ps
module fmf_frame_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 80,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             wrEn,
  input  wire logic [AW-1:0]    wrAddr,
  input  wire logic [WIDTH-1:0] wrData,
  input  wire logic [AW-1:0]    rdAddr,
  output logic      [WIDTH-1:0] rdData
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] rdData_reg;
  logic [WIDTH-1:0] rdData_next;

  // out-of-range reads return zero
  always_comb begin
    rdData_next = (int'(rdAddr) < DEPTH) ? mem[rdAddr] : '0;
  end

  // write port, array has no reset
  always_ff @(posedge clk) begin
    if (wrEn && int'(wrAddr) < DEPTH) begin
      mem[wrAddr] <= wrData;
    end
  end

  // read data register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData_reg <= '0;
    end else begin
      rdData_reg <= rdData_next;
    end
  end

  assign rdData = rdData_reg;
endmodule

// *** testbench/fmf_master_model.sv ***
// serial master model: sends request characters and stalls the transmit side
`timescale 1ns/100ps
module fmf_master_model (
  input  wire logic       clk,
  output logic            rxValid,
  output logic      [7:0] rxByte,
  output logic            rxIdle,
  output logic            txReady
);
  logic [7:0] frm[$];
  int         cyc;
  int         endCyc;
  // ==========================================
  // idle line levels
  initial begin
    rxValid = 1'b0;
    rxByte  = 8'h5A;
    rxIdle  = 1'b0;
    txReady = 1'b0;
    cyc     = 0;
    endCyc  = 0;
  end
  // cycle count and random acceptance of response characters
  always @(posedge clk) begin
    cyc     <= cyc + 1;
    txReady <= ($urandom % 4) != 0;
  end
  // ==========================================
  // only the master opens a transaction
  task automatic send(input bit asc);
    foreach (frm[i]) begin
      @(posedge clk);
      rxValid <= 1'b1;
      rxByte  <= frm[i];
      @(posedge clk);
      rxValid <= 1'b0;
      rxByte  <= ~frm[i]; // no stale byte between characters
      endCyc  = cyc;
    end
    if (!asc) begin
      @(posedge clk);
      rxIdle <= 1'b1;
      @(posedge clk);
      rxIdle <= 1'b0;
      endCyc = cyc;
    end
  endtask
endmodule

// *** testbench/fmf_follower_framer_bench.sv ***
// self-checking bench of the follower framer
`timescale 1ns/100ps
module fmf_follower_framer_bench;
  import fmf_pkg::*;
  typedef logic [7:0] fmf_bq_t[$];
  localparam int RC = 20;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       asciiMode = 1'b0;
  logic [7:0] stationId = 8'h11;
  logic       rxValid, rxIdle, txValid, txReady, appReq;
  logic [7:0] rxByte, txByte, appRdByte;
  logic       appWrEn = 1'b0;
  logic       appDone = 1'b0;
  logic [7:0] appWrByte = 8'h00;
  logic [6:0] appRdIdx = 7'h00;
  logic [6:0] appWrIdx = 7'h00;
  logic [2:0] appExc = 3'h0;
  logic [2:0] appExcSel = 3'h0;
  fmf_hdr_t   appHdr;
  fmf_bq_t    pl, rsp, expQ, appData;
  bit         firstPend = 0;
  int         badCount = 0;
  int         cmpCount = 0;
  int         appSeen = 0;
  int         dly, n;
  always #50 clk = ~clk;
  fmf_follower_framer #(.RESP_CYCLES(RC)) u_dut (.clk(clk), .rst_b(rst_b), .asciiMode(asciiMode),
    .stationId(stationId), .rxValid(rxValid), .rxByte(rxByte), .rxIdle(rxIdle), .txValid(txValid),
    .txByte(txByte), .txReady(txReady), .appReq(appReq), .appHdr(appHdr), .appRdIdx(appRdIdx),
    .appRdByte(appRdByte), .appWrEn(appWrEn), .appWrIdx(appWrIdx), .appWrByte(appWrByte),
    .appDone(appDone), .appExc(appExc));
  fmf_master_model u_mst (.clk(clk), .rxValid(rxValid), .rxByte(rxByte), .rxIdle(rxIdle),
    .txReady(txReady));
  // ==========================================
  // comparison and verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      badCount++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic giveVerdict();
    if (badCount == 0 && cmpCount > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================
  // frame building: binary with CRC, text with LRC
  function automatic logic [7:0] hx(input logic [3:0] v);
    return (v < 4'hA) ? 8'h30 + v : 8'h37 + v;
  endfunction
  function automatic fmf_bq_t frame(input bit asc, input fmf_bq_t b, input bit bad);
    fmf_bq_t     f;
    logic [15:0] c;
    logic [7:0]  s;
    c = 16'hFFFF;
    s = 8'h00;
    foreach (b[i]) begin
      c ^= {8'h00, b[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      s += b[i];
    end
    s = -s;
    c[0] ^= bad;
    s[0] ^= bad;
    if (!asc) begin
      f = {b, c[7:0], c[15:8]};
    end else begin
      f = {8'h3A};
      foreach (b[i]) f = {f, hx(b[i][7:4]), hx(b[i][3:0])};
      f = {f, hx(s[7:4]), hx(s[3:0]), 8'h0D, 8'h0A};
    end
    return f;
  endfunction
  // ==========================================
  // one request: note expected characters, send, wait for the answer
  task automatic run(input bit asc, input bit bad);
    int k;
    asciiMode <= asc;
    u_mst.frm = frame(asc, pl, bad);
    if (rsp.size() > 0) begin
      expQ = frame(asc, rsp, 1'b0);
      firstPend = 1;
    end
    u_mst.send(asc);
    k = 0;
    while (expQ.size() > 0 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    check(expQ.size(), 0);
    repeat (RC + 40) @(posedge clk);
  endtask
  task automatic loopReq(input logic [7:0] a, input int len, input bit own);
    pl = {a, 8'h08};
    repeat (len - 2) pl.push_back(8'($urandom));
    rsp = {};
    if (own) rsp = pl;
  endtask
  // ==========================================
  // response monitor: oldest note against each accepted character
  always @(posedge clk) begin
    if (firstPend && txValid === 1'b1) begin
      dly = u_mst.cyc - u_mst.endCyc;
      check(dly >= RC && dly <= RC + 8, 1);
      firstPend = 0;
    end
    if (rst_b && txValid === 1'b1 && txReady) begin
      check(expQ.size() > 0, 1);
      if (expQ.size() > 0) check(txByte, expQ.pop_front());
    end
  end
  // application model: serves requests, supplies read data and a status
  initial forever begin
    @(posedge clk);
    if (appReq === 1'b1) begin
      appSeen++;
      check(appHdr.addr, pl[0]);
      check(appHdr.func, pl[1]);
      if (pl[1] == FN_READ) check(appHdr.count, {pl[4], pl[5]});
      check(appHdr.regAddr, {pl[2], pl[3]});
      if (pl[1] == FN_WRITEN) check(appHdr.byteCnt, pl[6]);
      appRdIdx <= 7'h01;
      repeat (2) @(posedge clk);
      check(appRdByte, pl[1]);
      foreach (appData[i]) begin
        appWrEn   <= 1'b1;
        appWrIdx  <= 7'(3 + i);
        appWrByte <= appData[i];
        @(posedge clk);
      end
      appWrEn <= 1'b0;
      appDone <= 1'b1;
      appExc  <= appExcSel;
      @(posedge clk);
      appDone <= 1'b0;
      @(posedge clk);
    end
  end
  // ==========================================
  // watchdog
  initial begin
    repeat (30000) @(posedge clk);
    badCount++;
    giveVerdict();
  end
  // main sequence
  initial begin
    void'($urandom(32'h8476_785d));
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    loopReq(8'h11, 8, 1);
    run(0, 0);
    loopReq(8'h12, 8, 0);
    run(0, 0);
    loopReq(8'h11, 8, 0);
    run(0, 1);
    loopReq(8'h11, 78, 1);
    run(0, 0);
    loopReq(8'h11, 79, 0);
    run(0, 0);
    loopReq(8'h11, 6, 1);
    run(1, 0);
    loopReq(8'h11, 6, 0);
    run(1, 1);
    stationId <= 8'hFE;
    loopReq(8'hFE, 6, 1);
    run(0, 0);
    stationId <= 8'h11;
    pl = {8'h11, 8'h05, 8'h00, 8'h00};
    rsp = {8'h11, 8'h85, 8'h01};
    run(0, 0);
    pl = {8'h11, 8'h03, 8'h00, 8'h10, 8'h00, 8'h02};
    repeat (4) appData.push_back(8'($urandom));
    rsp = {8'h11, 8'h03, 8'h04, appData};
    run(1, 0);
    appData = {};
    pl = {8'h11, 8'h06, 8'h00, 8'h05, 8'h12, 8'h34};
    appExcSel = 3'h4;
    rsp = {8'h11, 8'h86, 8'h04};
    run(0, 0);
    appExcSel = 3'h0;
    pl = {8'h11, 8'h03, 8'h00, 8'h10, 8'h00, 8'h00};
    rsp = {8'h11, 8'h83, 8'h03};
    run(0, 0);
    pl = {8'h11, 8'h10, 8'h00, 8'h02, 8'h00, 8'h01, 8'h02, 8'hAB, 8'hCD};
    rsp = pl[0:5];
    run(1, 0);
    n = appSeen;
    pl = {8'h00, 8'h06, 8'h00, 8'h01, 8'h00, 8'h07};
    rsp = {};
    run(0, 0);
    check(appSeen, n + 1);
    giveVerdict();
  end
endmodule
